/* hw/asbp_sram_ctrl.v */
// host-side controller sequencing an asynchronous byte-wide static memory
// Contract
// - a write happens while chip select and write strobe are both low, storing the data byte.
// - a read happens with chip select and output gate low and write strobe high.
// - write data set-up and hold are timed against the edge that ends the write.
// - the first access waits at least 1 us after power is good.
// - a strobe-controlled write with gate low lasts release delay plus data set-up.
// - write data is never driven while the memory may still drive the data lines.
`include "asbp_sram_regs.vh"

module asbp_sram_ctrl #(
  parameter IW = `ASBP_INDEX_W,
  parameter DW = `ASBP_DATA_W,
  parameter POWER_UP_CYC = `ASBP_POWER_UP_CYC
) (
  input wire ref_clk,
  input wire rst,
  // user side
  input wire reqValid,
  output wire reqReady,
  input wire reqWrite,
  input wire [IW-1:0] reqIndex,
  input wire [DW-1:0] reqData,
  output reg rdValid_r,
  output reg [DW-1:0] rdData_r,
  output wire powerReady,
  // memory pins
  output reg chipSelN_r,
  output reg outGateN_r,
  output reg writeStrobeN_r,
  output reg [IW-1:0] wordIndex_r,
  output reg [DW-1:0] dataLinesOut_r,
  output reg dataLinesOe_r,
  input wire [DW-1:0] dataLinesIn
);

  // ----------------------------------------
  // states and counts
  // ----------------------------------------
  localparam [2:0] ST_POWER = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_READ = 3'h2;
  localparam [2:0] ST_RTURN = 3'h3;
  localparam [2:0] ST_WSETUP = 3'h4;
  localparam [2:0] ST_WPULSE = 3'h5;
  localparam [2:0] ST_WHOLD = 3'h6;
  localparam [2:0] ST_RCAP = 3'h7;

  localparam integer READ_N = `ASBP_READ_CYC;
  localparam integer PULSE_N = (`ASBP_PULSE_CYC > `ASBP_STROBE_CYC) ?
    `ASBP_PULSE_CYC : `ASBP_STROBE_CYC;
  localparam integer TURN_N = `ASBP_TURN_CYC;
  localparam integer UP_N = POWER_UP_CYC;

  // counts cut to the 16-bit counter on purpose; real counts sit far below its range
  localparam [15:0] READ_CYC = READ_N[15:0];
  localparam [15:0] PULSE_CYC = PULSE_N[15:0];
  localparam [15:0] TURN_CYC = TURN_N[15:0];
  localparam [15:0] SYNC_CYC = 16'h0002;
  localparam [15:0] UP_CYC = UP_N[15:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg [IW-1:0] index_nxt;
  reg [DW-1:0] wdata_nxt;
  reg cs_nxt;
  reg og_nxt;
  reg ws_nxt;
  reg oe_nxt;
  reg rdValid_nxt;
  reg [DW-1:0] rdData_nxt;
  wire [DW-1:0] dataSync;

  // memory data pins arrive asynchronously
  asbp_sync2 #(.W(DW)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(dataLinesIn),
    .dout(dataSync)
  );

  assign reqReady = (state_r == ST_IDLE);
  assign powerReady = (state_r != ST_POWER);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // every pin changes from a flop so no glitch reaches the memory
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    index_nxt = wordIndex_r;
    wdata_nxt = dataLinesOut_r;
    cs_nxt = chipSelN_r;
    og_nxt = outGateN_r;
    ws_nxt = writeStrobeN_r;
    oe_nxt = dataLinesOe_r;
    rdValid_nxt = 1'b0;
    rdData_nxt = rdData_r;
    case (state_r)
      ST_POWER: begin
        // hold off all access after power-up
        if (cnt_r >= UP_CYC - 16'h0001) begin
          state_nxt = ST_IDLE;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_IDLE: begin
        cs_nxt = 1'b1; // deselect between accesses, memory stands
        og_nxt = 1'b1;
        ws_nxt = 1'b1;
        oe_nxt = 1'b0;
        if (reqValid) begin
          index_nxt = reqIndex; // index set on the same edge that takes select low
          cnt_nxt = 16'h0000;
          cs_nxt = 1'b0;
          if (reqWrite) begin
            wdata_nxt = reqData;
            state_nxt = ST_WSETUP;
          end else begin
            og_nxt = 1'b0; // strobe held high for a read
            state_nxt = ST_READ;
          end
        end
      end
      ST_READ: begin
        // hold select and gate for the full read cycle
        if (cnt_r >= READ_CYC - 16'h0001) begin
          state_nxt = ST_RCAP;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_RCAP: begin
        // wait out the synchroniser then take the byte
        if (cnt_r >= SYNC_CYC - 16'h0001) begin
          rdData_nxt = dataSync;
          rdValid_nxt = 1'b1;
          cs_nxt = 1'b1;
          og_nxt = 1'b1;
          state_nxt = ST_RTURN;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_RTURN: begin
        // let the memory release the lines before anyone drives them
        if (cnt_r >= TURN_CYC - 16'h0001) begin
          state_nxt = ST_IDLE;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_WSETUP: begin
        // gate is high so the memory is released; strobe falls and drive starts on the same edge
        ws_nxt = 1'b0; // write interval opens on the overlap
        oe_nxt = 1'b1;
        state_nxt = ST_WPULSE;
      end
      ST_WPULSE: begin
        // pulse covers release delay plus data set-up
        if (cnt_r >= PULSE_CYC - 16'h0001) begin
          ws_nxt = 1'b1; // strobe alone ends the write, select stays low
          state_nxt = ST_WHOLD;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_WHOLD: begin
        // data held one cycle past the strobe rise
        oe_nxt = 1'b0;
        cs_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_POWER;
      cnt_r <= 16'h0000;
      chipSelN_r <= 1'b1;
      outGateN_r <= 1'b1;
      writeStrobeN_r <= 1'b1;
      wordIndex_r <= {IW{1'b0}};
      dataLinesOut_r <= {DW{1'b0}};
      dataLinesOe_r <= 1'b0;
      rdValid_r <= 1'b0;
      rdData_r <= {DW{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      chipSelN_r <= cs_nxt;
      outGateN_r <= og_nxt;
      writeStrobeN_r <= ws_nxt;
      wordIndex_r <= index_nxt;
      dataLinesOut_r <= wdata_nxt;
      dataLinesOe_r <= oe_nxt;
      rdValid_r <= rdValid_nxt;
      rdData_r <= rdData_nxt;
    end
  end

endmodule

/* hw/asbp_sram_regs.vh */
// timing constants and pin widths for the byte-wide static memory controller
`ifndef ASBP_SRAM_REGS_VH
`define ASBP_SRAM_REGS_VH

// ----------------------------------------
// clock and widths
// ----------------------------------------
`define ASBP_CLK_PERIOD_NS 10
`define ASBP_INDEX_W 19
`define ASBP_DATA_W 8
`define ASBP_DEPTH 524288

// ----------------------------------------
// memory timing, ns except power-up in us (slowest grade)
// ----------------------------------------
`define ASBP_POWER_UP_US 1
`define ASBP_READ_CYCLE_NS 15
`define ASBP_WRITE_CYCLE_NS 15
`define ASBP_WRITE_PULSE_NS 10
`define ASBP_WRITE_RELEASE_NS 7
`define ASBP_WRITE_SETUP_NS 7
`define ASBP_OUT_RELEASE_NS 7

// ----------------------------------------
// derived cycle counts, least times round up
// ----------------------------------------
`define ASBP_CYC_UP(ns) (((ns) + `ASBP_CLK_PERIOD_NS - 1) / `ASBP_CLK_PERIOD_NS)
`define ASBP_POWER_UP_CYC `ASBP_CYC_UP(`ASBP_POWER_UP_US * 1000)
`define ASBP_READ_CYC `ASBP_CYC_UP(`ASBP_READ_CYCLE_NS)
`define ASBP_PULSE_CYC `ASBP_CYC_UP(`ASBP_WRITE_PULSE_NS)
`define ASBP_STROBE_CYC `ASBP_CYC_UP(`ASBP_WRITE_RELEASE_NS + `ASBP_WRITE_SETUP_NS)
`define ASBP_WRITE_CYC `ASBP_CYC_UP(`ASBP_WRITE_CYCLE_NS)
`define ASBP_TURN_CYC `ASBP_CYC_UP(`ASBP_OUT_RELEASE_NS)

`endif

/* hw/asbp_sync2.v */
// two-flop synchroniser for a bus of pin inputs
module asbp_sync2 #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule

/* tb/asbp_mem_model.sv */
// behavioural byte-wide static memory seen from its pins
module asbp_mem_model (
  input wire logic csN,
  input wire logic ogN,
  input wire logic wsN,
  input wire logic [18:0] idx,
  input wire logic [7:0] hostData,
  input wire logic hostOe,
  output logic [7:0] busLevel,
  output logic clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [bit [18:0]];
  logic [7:0] lastOut = 8'h00;
  wire drive = !csN && !ogN && wsN;
  // a write ends on the first of select or strobe to rise
  always @(posedge wsN) if (!csN) mem[idx] = hostData;
  always @(posedge csN) if (!wsN) mem[idx] = hostData;
  // released lines show the inverse of the last byte, not a stale copy
  always @* if (drive) lastOut = mem.exists(idx) ? mem[idx] : 8'h00;
  assign busLevel = hostOe ? hostData : (drive ? lastOut : ~lastOut);
  initial clash = 1'b0;
  always @(posedge (hostOe && drive)) clash = 1'b1;
endmodule

/* tb/asbp_sram_chk_sva.sv */
// concurrent checks on the static memory controller pins
module asbp_sram_chk #(parameter int POWER_UP_CYC = 100) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic reqWrite,
  input wire logic rdValid_r,
  input wire logic powerReady,
  input wire logic chipSelN_r,
  input wire logic outGateN_r,
  input wire logic writeStrobeN_r,
  input wire logic dataLinesOe_r
);
  timeunit 1ns;
  timeprecision 1ps;
  int upCnt_r;
  // edges since reset, saturating so a long run cannot wrap it
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) upCnt_r <= 0;
    else if (upCnt_r < 1000) upCnt_r <= upCnt_r + 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence sTake; reqValid && reqReady; endsequence
  sequence sPulse; !writeStrobeN_r [*2] ##1 writeStrobeN_r; endsequence
  AST_GATE_SEL: assert property (!outGateN_r |-> !chipSelN_r && writeStrobeN_r)
    else $error("gate low outside a selected read");
  AST_STROBE_SEL: assert property (!writeStrobeN_r |-> !chipSelN_r)
    else $error("strobe low while deselected");
  AST_NO_CLASH: assert property (dataLinesOe_r |-> outGateN_r)
    else $error("write data driven with gate low");
  AST_DATA_HOLD: assert property ($rose(writeStrobeN_r) |-> dataLinesOe_r && !chipSelN_r)
    else $error("data or select dropped at strobe rise");
  AST_PULSE: assert property ($fell(writeStrobeN_r) |-> sPulse)
    else $error("write pulse length wrong");
  AST_READ_LEN: assert property ($fell(outGateN_r) |-> !outGateN_r [*2])
    else $error("read cycle too short");
  AST_READ_ANS: assert property (sTake ##0 !reqWrite |-> ##[4:5] rdValid_r)
    else $error("read data not returned in time");
  AST_BUSY: assert property (sTake |=> !reqReady [*4])
    else $error("ready during an access");
  AST_POWER: assert property ($rose(powerReady) |-> upCnt_r >= POWER_UP_CYC)
    else $error("power-up wait too short");
  AST_POWER_SEL: assert property (!powerReady |-> chipSelN_r)
    else $error("access before power-up wait");
endmodule

bind asbp_sram_ctrl asbp_sram_chk #(.POWER_UP_CYC(POWER_UP_CYC)) u_chk (.ref_clk, .rst,
  .reqValid, .reqReady, .reqWrite, .rdValid_r, .powerReady, .chipSelN_r, .outGateN_r,
  .writeStrobeN_r, .dataLinesOe_r);

/* tb/testbench.sv */
// self-checking bench for the static memory controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 4;
  logic ref_clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
  logic [18:0] reqIndex = 19'h0, wordIndex_r;
  logic [7:0] reqData = 8'h0, rdData_r, dataLinesIn, dataLinesOut_r, q;
  logic reqReady, rdValid_r, powerReady, chipSelN_r, outGateN_r, writeStrobeN_r;
  logic dataLinesOe_r, clash;
  logic [18:0] ix [3] = '{19'h0, 19'h7ffff, 19'h2a5c3};
  int n_fail = 0, total_checks = 0, cyc = 0;
  // ----
  // design and memory
  // ----
  asbp_sram_ctrl #(.POWER_UP_CYC(P)) u_dut (.ref_clk, .rst, .reqValid, .reqReady, .reqWrite,
    .reqIndex, .reqData, .rdValid_r, .rdData_r, .powerReady, .chipSelN_r, .outGateN_r,
    .writeStrobeN_r, .wordIndex_r, .dataLinesOut_r, .dataLinesOe_r, .dataLinesIn);
  asbp_mem_model u_mem (.csN(chipSelN_r), .ogN(outGateN_r), .wsN(writeStrobeN_r),
    .idx(wordIndex_r), .hostData(dataLinesOut_r), .hostOe(dataLinesOe_r),
    .busLevel(dataLinesIn), .clash(clash));
  always #5 ref_clk = ~ref_clk;
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one request; held until taken, read data caught on its pulse
  task automatic req(input logic w, input logic [18:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    reqValid = 1'b1; reqWrite = w; reqIndex = i; reqData = d;
    // ready is judged at a falling edge, where it stands settled
    while (reqReady !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk) reqValid = 1'b0;
    n = 0;
    if (!w) do @(posedge ref_clk) #1; while (rdValid_r !== 1'b1 && ++n < 20);
    q = rdData_r;
  endtask
  task automatic complete_run;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_power;
    int n;
    n = 0;
    while (powerReady !== 1'b1 && n < 300) begin
      @(posedge ref_clk) #1;
      n++;
      if (chipSelN_r !== 1'b1) chk(32'(chipSelN_r), 32'h1);
    end
    chk(32'(n >= P), 32'h1);
    $display("power-up test done");
  endtask
  task automatic t_rw;
    foreach (ix[k]) req(1'b1, ix[k], ix[k][7:0] ^ 8'h3c);
    foreach (ix[k]) begin
      req(1'b0, ix[k], 8'h0);
      chk(32'(q), 32'(ix[k][7:0] ^ 8'h3c));
    end
    $display("write and read test done");
  endtask
  task automatic t_b2b;
    req(1'b1, 19'h1, 8'h3c);
    chk(32'(reqReady), 32'h0);
    req(1'b1, 19'h1, 8'hc3);
    req(1'b0, 19'h1, 8'h0);
    chk(32'(q), 32'hc3);
    chk(32'(clash), 32'h0);
    $display("back-to-back test done");
  endtask
  // reset in the middle of a read: pins idle at once, wait runs again, memory keeps data
  task automatic t_reset;
    @(negedge ref_clk);
    while (reqReady !== 1'b1) @(negedge ref_clk);
    reqValid = 1'b1; reqWrite = 1'b0; reqIndex = 19'h1;
    @(negedge ref_clk) reqValid = 1'b0;
    rst = 1'b1;
    #1;
    chk(32'({chipSelN_r, outGateN_r, writeStrobeN_r, dataLinesOe_r}), 32'he);
    chk(32'({powerReady, reqReady, rdValid_r}), 32'h0);
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_power;
    req(1'b0, 19'h1, 8'h0);
    chk(32'(q), 32'hc3);
    $display("mid-run reset test done");
  endtask
  // bounded run: a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    t_power;
    t_rw;
    t_b2b;
    t_reset;
    complete_run;
  end
endmodule
